// ### src/sys_ctl_pkg.sv
package sys_ctl_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] SYSTEM_CONTROL_OFS    = 8'h11;
	localparam logic [7:0] SYSTEM_STATUS_OFS     = 8'h12;
	localparam logic [7:0] HARDWARE_REVISION_OFS = 8'h18;
	localparam logic [7:0] PEND_CTL_OFS          = 8'h1A;
	// ****************************************
	// System control fields
	// ****************************************
	localparam int INTERRUPT_POLARITY_BIT    = 7;
	localparam int REMOTE_WAKE_ENABLE_BIT    = 6;
	localparam int SUSPEND_INT_ENABLE_BIT    = 5;
	localparam int BUS_RESET_INT_ENABLE_BIT  = 4;
	localparam int SOFTWARE_RESET_CTL_BIT    = 3;
	localparam int INTERRUPT_PULSE_MODE_BIT  = 2;
	localparam int GLOBAL_INT_ENABLE_BIT     = 1;
	// ****************************************
	// System status and pend control fields
	// ****************************************
	localparam int SUSPEND_POWER_OFF_BIT      = 4;
	localparam int SUSPEND_DETECT_DISABLE_BIT = 3;
	localparam int RESUME_DETECTED_BIT        = 2;
	localparam int SUSPEND_BIT                = 1;
	localparam int BUS_RESET_DETECTED_BIT     = 0;
	localparam int PEND_BIT                   = 0;
	// ****************************************
	// Reset values, masks and timing
	// ****************************************
	localparam logic [7:0] CONTROL_RESET_VALUE = 8'h00;
	localparam logic [7:0] STATUS_RESET_VALUE  = 8'h00;
	localparam logic [7:0] RESERVED_CTL_MASK   = 8'hFE;
	localparam logic [7:0] RESERVED_STAT_MASK  = 8'h1F;
	localparam int         CLK_PERIOD_NS       = 8;
	localparam int         PULSE_LEN_NS        = 2 * CLK_PERIOD_NS;
	localparam int         PULSE_CYCLES        = (PULSE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### src/irq_pulse_gen.sv
module irq_pulse_gen
(
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic event_i,
	output logic      active_o
);
	logic [1:0] count_r;
	logic [1:0] count_nxt;

	// ****************************************
	// Pulse stretcher
	// ****************************************
	always_comb
	begin
		count_nxt = count_r;
		if (event_i)
			count_nxt = 2'(sys_ctl_pkg::PULSE_CYCLES);
		else if (count_r != 2'h0)
			count_nxt = count_r - 2'h1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			count_r <= 2'h0;
		else
			count_r <= count_nxt;
	end

	assign active_o = (count_r != 2'h0);
endmodule

// ### src/usb_device_system_control_status.sv
// Implementation choice: the strobed register port.
module usb_device_system_control_status
#(
	parameter logic [3:0] MAIN_REVISION = 4'h0, // Arbitrary value
	parameter logic [3:0] SUB_REVISION  = 4'h0  // Arbitrary value
)
(
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o,
	input  wire logic       bus_suspend_i,
	input  wire logic       bus_non_idle_i,
	input  wire logic       bus_reset_i,
	input  wire logic       wake_request_input_pin_n_i,
	input  wire logic       endpoint_status_i,
	input  wire logic       missed_frame_start_flag_i,
	output logic            interrupt_output_pin_o,
	output logic            device_reset_o,
	output logic            device_suspended_o,
	output logic            remote_resume_o,
	output logic            suspend_power_off_o
);
	typedef enum logic [1:0] {ST_ACTIVE, ST_SUSPENDED, ST_WAKING} power_type;

	logic [7:0] system_control_r;
	logic [7:0] system_control_nxt;
	logic [4:0] system_status_r;
	logic [4:0] system_status_nxt;
	logic       suspend_ctl_r;
	logic       suspend_ctl_nxt;
	logic       pend_r;
	logic       pend_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	power_type  power_r;
	power_type  power_nxt;
	logic       irq_r;
	logic       irq_nxt;
	logic       reset_r;
	logic       reset_nxt;
	logic       remote_resume_r;
	logic       remote_resume_nxt;
	logic       int_cause;
	logic       int_cause_d_r;
	logic       pulse_active;
	logic       wake_event;
	logic       suspend_cmd;

	// ****************************************
	// Address decode
	// ****************************************
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	// ****************************************
	// Register writes and status
	// ****************************************
	always_comb
	begin
		system_control_nxt = system_control_r;
		system_status_nxt  = system_status_r;
		suspend_ctl_nxt    = suspend_ctl_r;
		pend_nxt           = pend_r;
		suspend_cmd        = 1'b0;
		if (wr_i && hit(addr_i, sys_ctl_pkg::SYSTEM_CONTROL_OFS))
			system_control_nxt = wdata_i & sys_ctl_pkg::RESERVED_CTL_MASK;
		else if (wr_i && hit(addr_i, sys_ctl_pkg::PEND_CTL_OFS))
			pend_nxt = wdata_i[sys_ctl_pkg::PEND_BIT];
		else if (wr_i && hit(addr_i, sys_ctl_pkg::SYSTEM_STATUS_OFS))
		begin
			// Shared bits only follow writes while pend is set
			if (pend_r)
			begin
				system_status_nxt[sys_ctl_pkg::SUSPEND_POWER_OFF_BIT] =
					wdata_i[sys_ctl_pkg::SUSPEND_POWER_OFF_BIT];
				suspend_ctl_nxt = wdata_i[sys_ctl_pkg::SUSPEND_BIT];
				suspend_cmd = suspend_ctl_r && !wdata_i[sys_ctl_pkg::SUSPEND_BIT];
			end
			system_status_nxt[sys_ctl_pkg::SUSPEND_DETECT_DISABLE_BIT] =
				wdata_i[sys_ctl_pkg::SUSPEND_DETECT_DISABLE_BIT];
			if (!wdata_i[sys_ctl_pkg::RESUME_DETECTED_BIT])
				system_status_nxt[sys_ctl_pkg::RESUME_DETECTED_BIT] = 1'b0;
			if (!wdata_i[sys_ctl_pkg::BUS_RESET_DETECTED_BIT])
				system_status_nxt[sys_ctl_pkg::BUS_RESET_DETECTED_BIT] = 1'b0;
		end
		// Hardware sets win over firmware clears
		if (bus_reset_i)
			system_status_nxt[sys_ctl_pkg::BUS_RESET_DETECTED_BIT] = 1'b1;
		if (wake_event)
			system_status_nxt[sys_ctl_pkg::RESUME_DETECTED_BIT] = 1'b1;
		if (reset_r)
		begin
			system_control_nxt = sys_ctl_pkg::CONTROL_RESET_VALUE |
				(system_control_nxt & 8'h08);
			system_status_nxt = 5'(sys_ctl_pkg::STATUS_RESET_VALUE);
			suspend_ctl_nxt = 1'b0;
			pend_nxt = 1'b0;
		end
		system_status_nxt[sys_ctl_pkg::SUSPEND_BIT] = (power_nxt != ST_ACTIVE);
	end

	// ****************************************
	// Suspend and resume sequencing
	// ****************************************
	assign wake_event = (power_r == ST_SUSPENDED) && (bus_non_idle_i ||
		(system_control_r[sys_ctl_pkg::REMOTE_WAKE_ENABLE_BIT] &&
		!wake_request_input_pin_n_i));

	always_comb
	begin
		power_nxt = power_r;
		remote_resume_nxt = 1'b0;
		case (power_r)
			ST_ACTIVE:
				if (suspend_cmd || (bus_suspend_i &&
					!system_status_r[sys_ctl_pkg::SUSPEND_DETECT_DISABLE_BIT] &&
					!system_status_r[sys_ctl_pkg::RESUME_DETECTED_BIT]))
					power_nxt = ST_SUSPENDED;
			ST_SUSPENDED:
				if (wake_event)
				begin
					power_nxt = ST_WAKING;
					remote_resume_nxt = !bus_non_idle_i;
				end
			ST_WAKING:
				if (!bus_suspend_i)
					power_nxt = ST_ACTIVE;
			default:
				power_nxt = ST_ACTIVE;
		endcase
	end

	// ****************************************
	// Software reset and interrupt output
	// ****************************************
	always_comb
	begin
		reset_nxt = system_control_nxt[sys_ctl_pkg::SOFTWARE_RESET_CTL_BIT] &&
			(power_r == ST_ACTIVE);
		int_cause = system_control_r[sys_ctl_pkg::GLOBAL_INT_ENABLE_BIT] &&
			(endpoint_status_i || missed_frame_start_flag_i ||
			(system_status_r[sys_ctl_pkg::BUS_RESET_DETECTED_BIT] &&
			system_control_r[sys_ctl_pkg::BUS_RESET_INT_ENABLE_BIT]) ||
			(system_status_r[sys_ctl_pkg::SUSPEND_BIT] &&
			system_control_r[sys_ctl_pkg::SUSPEND_INT_ENABLE_BIT]));
		if (system_control_r[sys_ctl_pkg::INTERRUPT_PULSE_MODE_BIT])
			irq_nxt = pulse_active &&
				system_control_r[sys_ctl_pkg::GLOBAL_INT_ENABLE_BIT];
		else
			irq_nxt = int_cause;
		irq_nxt = irq_nxt ~^ system_control_r[sys_ctl_pkg::INTERRUPT_POLARITY_BIT];
	end

	irq_pulse_gen u_pulse
	(
		.clk_i    (clk_i),
		.rstn_i   (rstn_i),
		.event_i  (int_cause && !int_cause_d_r),
		.active_o (pulse_active)
	);

	// ****************************************
	// Read data
	// ****************************************
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (rd_i && hit(addr_i, sys_ctl_pkg::SYSTEM_CONTROL_OFS))
			rdata_nxt = system_control_r & sys_ctl_pkg::RESERVED_CTL_MASK;
		else if (rd_i && hit(addr_i, sys_ctl_pkg::SYSTEM_STATUS_OFS))
			rdata_nxt = {3'b000, system_status_r};
		else if (rd_i && hit(addr_i, sys_ctl_pkg::HARDWARE_REVISION_OFS))
			rdata_nxt = {MAIN_REVISION, SUB_REVISION};
		else if (rd_i && hit(addr_i, sys_ctl_pkg::PEND_CTL_OFS))
			rdata_nxt = {7'h00, pend_r};
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			system_control_r <= sys_ctl_pkg::CONTROL_RESET_VALUE;
			system_status_r  <= 5'(sys_ctl_pkg::STATUS_RESET_VALUE);
			suspend_ctl_r    <= 1'b0;
			pend_r           <= 1'b0;
			rdata_r          <= 8'h00;
			power_r          <= ST_ACTIVE;
			irq_r            <= 1'b1;
			reset_r          <= 1'b0;
			remote_resume_r  <= 1'b0;
			int_cause_d_r    <= 1'b0;
		end
		else
		begin
			system_control_r <= system_control_nxt;
			system_status_r  <= system_status_nxt;
			suspend_ctl_r    <= suspend_ctl_nxt;
			pend_r           <= pend_nxt;
			rdata_r          <= rdata_nxt;
			power_r          <= power_nxt;
			irq_r            <= irq_nxt;
			reset_r          <= reset_nxt;
			remote_resume_r  <= remote_resume_nxt;
			int_cause_d_r    <= int_cause;
		end
	end

	assign rdata_o                = rdata_r;
	assign interrupt_output_pin_o = irq_r;
	assign device_reset_o         = reset_r;
	assign device_suspended_o     = system_status_r[sys_ctl_pkg::SUSPEND_BIT];
	assign remote_resume_o        = remote_resume_r;
	assign suspend_power_off_o    = system_status_r[sys_ctl_pkg::SUSPEND_POWER_OFF_BIT];

	// ****************************************
	// Assertions
	// ****************************************
	a_ctl_bit0_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(rd_i) && $past(addr_i) == sys_ctl_pkg::SYSTEM_CONTROL_OFS |-> !rdata_o[0])
		else $error("Control bit 0 read nonzero");
	a_stat_resv_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_i && addr_i == sys_ctl_pkg::SYSTEM_STATUS_OFS |=> rdata_o[7:5] == 3'b000)
		else $error("Status reserved bits nonzero");
	a_rev_value: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_i && addr_i == sys_ctl_pkg::HARDWARE_REVISION_OFS
		|=> rdata_o == {MAIN_REVISION, SUB_REVISION})
		else $error("Revision read wrong");
	a_reset_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
		bus_reset_i && !reset_r |=> system_status_r[0])
		else $error("Bus reset flag not set");
	a_suspend_detect_disable_blocks: assert property (@(posedge clk_i) disable iff (!rstn_i)
		power_r == ST_ACTIVE && system_status_r[3] && !suspend_cmd |=> power_r == ST_ACTIVE)
		else $error("Suspend detected while disabled");
	a_no_remote_wake: assert property (@(posedge clk_i) disable iff (!rstn_i)
		power_r == ST_SUSPENDED && !bus_non_idle_i && !system_control_r[6]
		|=> power_r != ST_WAKING)
		else $error("Remote wake without enable");
	a_irq_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!system_control_r[1] ##1 !system_control_r[1] |-> irq_r != system_control_r[7] ||
		$changed(system_control_r[7]))
		else $error("Interrupt asserted while globally disabled");
	a_pulse_two: assert property (@(posedge clk_i) disable iff (!rstn_i)
		system_control_r[2] && int_cause && !int_cause_d_r |=> pulse_active [*2])
		else $error("Pulse not two cycles");
	a_swreset_susp: assert property (@(posedge clk_i) disable iff (!rstn_i)
		power_r != ST_ACTIVE |=> !reset_r)
		else $error("Software reset while suspended");
	a_level_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!system_control_r[2] && int_cause |=> irq_r == $past(system_control_r[7]))
		else $error("Level interrupt not asserted");
	a_level_release: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!system_control_r[2] && !int_cause |=> irq_r != $past(system_control_r[7]))
		else $error("Level interrupt not released");
	a_pulse_gated: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!system_control_r[1] && system_control_r[2] |=> irq_r != $past(system_control_r[7]))
		else $error("Pulse sent while globally disabled");
	a_bus_reset_irq: assert property (@(posedge clk_i) disable iff (!rstn_i)
		system_control_r[1] && system_control_r[4] && system_status_r[0]
		|-> int_cause)
		else $error("Bus reset interrupt not raised");
	a_pend_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_i && addr_i == sys_ctl_pkg::SYSTEM_STATUS_OFS && !pend_r && !reset_r
		|=> $stable(suspend_power_off_o) && $stable(suspend_ctl_r))
		else $error("Shared bits written without pend");
	a_wake_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
		power_r == ST_SUSPENDED && bus_non_idle_i && !reset_r |=> system_status_r[2])
		else $error("Resume flag not set on wake");
	a_susp_status: assert property (@(posedge clk_i) disable iff (!rstn_i)
		device_suspended_o == (power_r != ST_ACTIVE))
		else $error("Suspend status out of step");
	a_resume_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
		remote_resume_o |=> !remote_resume_o)
		else $error("Remote resume longer than one cycle");
	a_swreset_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
		reset_r |=> system_status_r[4:2] == 3'b000 && !system_status_r[0] && !pend_r)
		else $error("Software reset left state behind");
endmodule

// ### testbench/fw_host.sv
module fw_host
(
	input  wire logic       clk_i,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Reserved bits of control (8'h11) and status (8'h12) go out as zero; other addresses are written unmasked
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o  <= a;
		wdata_o <= d & ((a == 8'h11) ? 8'hFE : (a == 8'h12) ? 8'h1F : 8'hFF);
		wr_o    <= 1'b1;
		@(posedge clk_i);
		wr_o    <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clk_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask
	// Suspend by hidden control, pend held, power-off set first
	task automatic suspend(input logic po);
		wr_reg(8'h1A, 8'h01);
		wr_reg(8'h12, {3'b000, po, 4'b0010});
		wr_reg(8'h12, {3'b000, po, 4'b0000});
		wr_reg(8'h1A, 8'h00);
	endtask
endmodule

// ### testbench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CTL = sys_ctl_pkg::SYSTEM_CONTROL_OFS;
	localparam logic [7:0] STA = sys_ctl_pkg::SYSTEM_STATUS_OFS;
	localparam logic [7:0] HWR = sys_ctl_pkg::HARDWARE_REVISION_OFS;
	logic       clk_i, rstn_i, wr, rd, sus, nidle, brst, wake_n, ep, mfs;
	logic       irq, dres, dsus, rres, spo;
	logic [7:0] addr, wdata, rdata, d;
	int         n_fail, cmp_count, k, hi;
	fw_host host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.rdata_i(rdata));
	// Revision values are arbitrary
	usb_device_system_control_status #(.MAIN_REVISION(4'h3), .SUB_REVISION(4'h5)) dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .bus_suspend_i(sus), .bus_non_idle_i(nidle),
		.bus_reset_i(brst), .wake_request_input_pin_n_i(wake_n), .endpoint_status_i(ep),
		.missed_frame_start_flag_i(mfs), .interrupt_output_pin_o(irq),
		.device_reset_o(dres), .device_suspended_o(dsus), .remote_resume_o(rres),
		.suspend_power_off_o(spo));
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd_reg(a, d);
		chk(d, exp);
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic pulse_rst;
		@(posedge clk_i);
		brst <= 1'b1;
		@(posedge clk_i);
		brst <= 1'b0;
	endtask
	function automatic logic [7:0] ctl_exp(input logic [7:0] v);
		return v & 8'hF6;
	endfunction
	function automatic logic [7:0] irq_exp(input logic [7:0] c, input logic on);
		return {7'h00, c[7] ~^ on};
	endfunction
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#200us;
		n_fail++;
		conclude();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		{rstn_i, sus, nidle, brst, ep, mfs} = 6'h00;
		wake_n = 1'b1;
		n_fail = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		d = $urandom(32'h9373_2bfe);
		rchk(CTL, 8'h00);
		rchk(STA, 8'h00);
		rchk(HWR, 8'h35);
		rchk(8'h13, 8'h00);
		$display("test reset done");
		for (k = 0; k < 8; k++)
		begin
			d = $urandom & 8'hF7;
			host.wr_reg(CTL, d);
			rchk(CTL, ctl_exp(d));
		end
		$display("test control done");
		foreach (d[i])
		begin
			d = (i % 2) ? 8'h82 : 8'h02;
			host.wr_reg(CTL, d);
			@(posedge clk_i);
			{ep, mfs} <= (i < 4) ? 2'b10 : 2'b01;
			w(3);
			chk({7'h00, irq}, irq_exp(d, 1'b1));
			host.wr_reg(CTL, d & 8'h80);
			w(3);
			chk({7'h00, irq}, irq_exp(d, 1'b0));
			@(posedge clk_i);
			{ep, mfs} <= 2'b00;
		end
		host.wr_reg(CTL, 8'h12);
		pulse_rst();
		w(3);
		rchk(STA, 8'h01);
		chk({7'h00, irq}, 8'h00);
		host.wr_reg(STA, 8'h00);
		w(3);
		chk({7'h00, irq}, 8'h01);
		host.wr_reg(CTL, 8'h02);
		pulse_rst();
		w(3);
		chk({7'h00, irq}, 8'h01);
		host.wr_reg(STA, 8'h00);
		host.wr_reg(CTL, 8'h16);
		pulse_rst();
		hi = 0;
		repeat (10)
		begin
			w(1);
			if (irq === 1'b0)
				hi++;
		end
		chk(hi[7:0], 8'h02);
		$display("test interrupt done");
		host.wr_reg(CTL, 8'h0A);
		w(2);
		chk({7'h00, dres}, 8'h01);
		rchk(CTL, 8'h08);
		host.wr_reg(CTL, 8'h00);
		w(2);
		chk({7'h00, dres}, 8'h00);
		rchk(STA, 8'h00);
		$display("test software reset done");
		host.wr_reg(STA, 8'h08);
		@(posedge clk_i);
		sus <= 1'b1;
		w(4);
		chk({7'h00, dsus}, 8'h00);
		host.wr_reg(STA, 8'h00);
		w(3);
		chk({7'h00, dsus}, 8'h01);
		host.wr_reg(STA, 8'h00);
		rchk(STA, 8'h02);
		@(posedge clk_i);
		nidle <= 1'b1;
		w(3);
		rchk(STA, 8'h06);
		@(posedge clk_i);
		{sus, nidle} <= 2'b00;
		w(3);
		rchk(STA, 8'h04);
		host.wr_reg(STA, 8'h00);
		$display("test bus suspend done");
		host.suspend(1'b1);
		w(2);
		chk({6'h00, dsus, spo}, 8'h03);
		host.wr_reg(CTL, 8'h48);
		w(2);
		chk({7'h00, dres}, 8'h00);
		host.wr_reg(CTL, 8'h40);
		@(posedge clk_i);
		wake_n <= 1'b0;
		hi = 0;
		repeat (6)
		begin
			w(1);
			if (rres === 1'b1)
				hi++;
		end
		chk(hi[7:0], 8'h01);
		@(posedge clk_i);
		wake_n <= 1'b1;
		host.rd_reg(STA, d);
		chk(d & 8'h04, 8'h04);
		$display("test remote wake done");
		conclude();
	end
endmodule
